//--- verilog/umr_pkg.sv
// Constants for the scratch, unlock and line test register bank
// Contract
// [RQ1] 16-bit read/write scratch with no side effects
// [RQ2] Scratch bytes split high/low, clear on resets
// [RQ3] Unpowered suspend locks all register writes
// [RQ4] Key AA37h written first re-enables writes
// [RQ5] Powered flag set means no lock
// [RQ6] Bit 7 forces high speed, no chirp
// [RQ7] Bit 4 forces full speed, no chirp
// [RQ8] Bit 3 toggles lines in pseudo-random pattern
// [RQ9] Bit 2 drives K, bit 1 drives J
// [RQ10] Bit 0 quiescent, NAK only high-speed IN
// [RQ11] Host sets at most one line-state bit
// [RQ12] Host sets at most one speed bit
// [RQ13] Active test mode persists until power cycle
// [RQ14] Bus reset clears line bits, keeps speed
package umr_pkg;
  localparam logic [7:0] ADDR_SCRATCH = 8'h78;
  localparam logic [7:0] ADDR_UNLOCK = 8'h7c;
  localparam logic [7:0] ADDR_TEST = 8'h84;
  localparam logic [15:0] UNLOCK_KEY_VALUE = 16'haa37;
  localparam logic [15:0] SCRATCH_RESET = 16'h0000;
  localparam logic [7:0] TEST_RESET = 8'h00;
  localparam int BIT_FORCE_HS = 7;
  localparam int BIT_FORCE_FS = 4;
  localparam int BIT_PATTERN = 3;
  localparam int BIT_DRIVE_K = 2;
  localparam int BIT_DRIVE_J = 1;
  localparam int BIT_QUIET_NAK = 0;
  localparam logic [7:0] TEST_WRITE_MASK = 8'h9f;
  localparam logic [7:0] TEST_BUSRST_KEEP = 8'h90;
  localparam logic [15:0] LFSR_SEED = 16'hace1;
endpackage

//--- verilog/umr_pattern_gen.sv
// Pseudo-random line pattern generator for the data line test
`timescale 1ns/1ns
module umr_pattern_gen #(
  parameter int WIDTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_run,
  output logic o_bit
);
  logic [WIDTH-1:0] lfsr;
  logic [WIDTH-1:0] next_lfsr;

  always_comb
  begin
    next_lfsr = lfsr;
    if (i_run)
    begin
      next_lfsr = {lfsr[WIDTH-2:0], lfsr[WIDTH-1] ^ lfsr[WIDTH-3] ^ lfsr[WIDTH-4] ^ lfsr[WIDTH-6]};
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      lfsr <= umr_pkg::LFSR_SEED[WIDTH-1:0];
    end
    else
    begin
      lfsr <= next_lfsr;
    end
  end

  assign o_bit = lfsr[WIDTH-1];
endmodule

//--- verilog/umr_regs.sv
// Scratch, write unlock and line test control registers
`timescale 1ns/1ns
module umr_regs (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_bus_rst,
  input wire logic i_suspend,
  input wire logic i_processor_powered_flag,
  input wire logic [7:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_host_write_strobe,
  input wire logic i_host_read_strobe,
  output logic [15:0] o_rdata,
  output logic o_write_locked,
  output logic o_force_high_speed,
  output logic o_force_full_speed,
  output logic o_chirp_disable,
  output logic o_line_drive_en,
  output logic o_line_dp,
  output logic o_line_dm,
  output logic o_quiescent_nak_enable
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] scratch_high_byte;
  logic [7:0] scratch_low_byte;
  logic [7:0] test_reg;
  logic [7:0] test_sticky;
  logic locked;
  logic suspend_d;
  logic [7:0] next_scratch_high_byte;
  logic [7:0] next_scratch_low_byte;
  logic [7:0] next_test_reg;
  logic [7:0] next_test_sticky;
  logic next_locked;
  logic [15:0] next_rdata;
  logic write_ok;
  logic pat_bit;
  logic next_drive_en;
  logic next_dp;
  logic next_dm;
  logic next_write_locked;
  logic next_force_high_speed;
  logic next_force_full_speed;
  logic next_chirp_disable;
  logic next_quiescent_nak;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  umr_pattern_gen #(
    .WIDTH(16)
  ) u_pat (
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_run(test_sticky[umr_pkg::BIT_PATTERN]),
    .o_bit(pat_bit)
  );

  // ----------------------------------------------------------------
  // Write path and lock
  // ----------------------------------------------------------------
  // Locked writes are ignored except the correct key
  assign write_ok = i_host_write_strobe && !locked; // [RQ3]

  always_comb
  begin
    next_scratch_high_byte = scratch_high_byte;
    next_scratch_low_byte = scratch_low_byte;
    next_test_reg = test_reg;
    next_test_sticky = test_sticky;
    next_locked = locked;
    if (i_suspend && !suspend_d && !i_processor_powered_flag)
    begin
      next_locked = 1'b1; // [RQ3] [RQ5]
    end
    if (locked && i_host_write_strobe && hit(i_addr, umr_pkg::ADDR_UNLOCK)
        && i_wdata == umr_pkg::UNLOCK_KEY_VALUE)
    begin
      next_locked = 1'b0; // [RQ4]
    end
    if (write_ok && hit(i_addr, umr_pkg::ADDR_SCRATCH))
    begin
      next_scratch_high_byte = i_wdata[15:8]; // [RQ1] [RQ2]
      next_scratch_low_byte = i_wdata[7:0];
    end
    if (write_ok && hit(i_addr, umr_pkg::ADDR_TEST))
    begin
      next_test_reg = i_wdata[7:0] & umr_pkg::TEST_WRITE_MASK;
    end
    if (i_bus_rst)
    begin
      next_scratch_high_byte = 8'h00; // [RQ2]
      next_scratch_low_byte = 8'h00;
      next_test_reg = next_test_reg & umr_pkg::TEST_BUSRST_KEEP; // [RQ14]
    end
    // Modes latch until chip reset, which stands for the power cycle
    next_test_sticky = test_sticky | test_reg; // [RQ13]
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      scratch_high_byte <= umr_pkg::SCRATCH_RESET[15:8];
      scratch_low_byte <= umr_pkg::SCRATCH_RESET[7:0];
      test_reg <= umr_pkg::TEST_RESET;
      test_sticky <= umr_pkg::TEST_RESET;
      locked <= 1'b0;
      suspend_d <= 1'b0;
    end
    else
    begin
      scratch_high_byte <= next_scratch_high_byte;
      scratch_low_byte <= next_scratch_low_byte;
      test_reg <= next_test_reg;
      test_sticky <= next_test_sticky;
      locked <= next_locked;
      suspend_d <= i_suspend;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Read data holds until the next read strobe
  always_comb
  begin
    next_rdata = o_rdata;
    if (i_host_read_strobe)
    begin
      if (hit(i_addr, umr_pkg::ADDR_SCRATCH))
      begin
        next_rdata = {scratch_high_byte, scratch_low_byte};
      end
      else if (hit(i_addr, umr_pkg::ADDR_TEST))
      begin
        next_rdata = {8'h00, test_reg};
      end
      else
      begin
        next_rdata = 16'h0000;
      end
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      o_rdata <= 16'h0000;
    end
    else
    begin
      o_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Mode and lock status
  // ----------------------------------------------------------------
  always_comb
  begin
    next_write_locked = next_locked;
    next_force_high_speed = next_test_sticky[umr_pkg::BIT_FORCE_HS]; // [RQ6]
    next_force_full_speed = next_test_sticky[umr_pkg::BIT_FORCE_FS]; // [RQ7]
    next_chirp_disable = next_test_sticky[umr_pkg::BIT_FORCE_HS]
                         | next_test_sticky[umr_pkg::BIT_FORCE_FS]; // [RQ6] [RQ7]
    // Kept in step with the quiescent line state, a cycle behind the latch
    next_quiescent_nak = test_sticky[umr_pkg::BIT_QUIET_NAK]; // [RQ10]
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      o_write_locked <= 1'b0;
      o_force_high_speed <= 1'b0;
      o_force_full_speed <= 1'b0;
      o_chirp_disable <= 1'b0;
      o_quiescent_nak_enable <= 1'b0;
    end
    else
    begin
      o_write_locked <= next_write_locked;
      o_force_high_speed <= next_force_high_speed;
      o_force_full_speed <= next_force_full_speed;
      o_chirp_disable <= next_chirp_disable;
      o_quiescent_nak_enable <= next_quiescent_nak;
    end
  end

  // ----------------------------------------------------------------
  // Line drive
  // ----------------------------------------------------------------
  always_comb
  begin
    next_drive_en = 1'b0;
    next_dp = 1'b0;
    next_dm = 1'b0;
    if (test_sticky[umr_pkg::BIT_PATTERN])
    begin
      next_drive_en = 1'b1; // [RQ8]
      next_dp = pat_bit;
      next_dm = !pat_bit;
    end
    else if (test_sticky[umr_pkg::BIT_DRIVE_K])
    begin
      next_drive_en = 1'b1; // [RQ9]
      next_dm = 1'b1;
    end
    else if (test_sticky[umr_pkg::BIT_DRIVE_J])
    begin
      next_drive_en = 1'b1; // [RQ9]
      next_dp = 1'b1;
    end
    else if (test_sticky[umr_pkg::BIT_QUIET_NAK])
    begin
      next_drive_en = 1'b1; // [RQ10]
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_sys_rst)
    begin
      o_line_drive_en <= 1'b0;
      o_line_dp <= 1'b0;
      o_line_dm <= 1'b0;
    end
    else
    begin
      o_line_drive_en <= next_drive_en;
      o_line_dp <= next_dp;
      o_line_dm <= next_dm;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_lock_on_susp: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RQ3]
    (i_suspend && !suspend_d && !i_processor_powered_flag && !(i_host_write_strobe
    && hit(i_addr, umr_pkg::ADDR_UNLOCK))) |=> o_write_locked)
    else $error("suspend did not lock writes");
  a_no_lock_powered: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RQ5]
    (!locked && !(i_suspend && !suspend_d && !i_processor_powered_flag)) |=> !locked)
    else $error("lock without unpowered suspend");
  a_key_unlocks: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RQ4]
    (locked && i_host_write_strobe && hit(i_addr, umr_pkg::ADDR_UNLOCK)
    && i_wdata == umr_pkg::UNLOCK_KEY_VALUE) |=> !locked)
    else $error("key did not unlock");
  a_locked_ignore: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RQ3]
    (locked && !i_bus_rst) |=> $stable({scratch_high_byte, scratch_low_byte}))
    else $error("write taken while locked");
  a_scratch_write: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RQ1]
    (write_ok && hit(i_addr, umr_pkg::ADDR_SCRATCH) && !i_bus_rst)
    |=> {scratch_high_byte, scratch_low_byte} == $past(i_wdata))
    else $error("scratch write lost");
  a_busrst_clear: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RQ2]
    i_bus_rst |=> (scratch_high_byte == 8'h00 && scratch_low_byte == 8'h00))
    else $error("scratch not cleared");
  a_busrst_speed: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RQ14]
    (i_bus_rst && !(write_ok && hit(i_addr, umr_pkg::ADDR_TEST)))
    |=> (test_reg[3:0] == 4'h0 && test_reg[7] == $past(test_reg[7])
    && test_reg[4] == $past(test_reg[4])))
    else $error("bus reset test bits wrong");
  a_mode_sticks: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RQ13]
    o_force_high_speed |=> o_force_high_speed [*8])
    else $error("test mode dropped");
  a_hs_chirp: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RQ6]
    test_reg[umr_pkg::BIT_FORCE_HS] |=> (o_force_high_speed && o_chirp_disable))
    else $error("high speed force missing");
  a_fs_chirp: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RQ7]
    test_reg[umr_pkg::BIT_FORCE_FS] |=> (o_force_full_speed && o_chirp_disable))
    else $error("full speed force missing");
  a_k_state: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RQ9]
    (test_sticky[2:1] == 2'b10 && test_sticky[3] == 1'b0)
    |=> (o_line_drive_en && !o_line_dp && o_line_dm))
    else $error("K state wrong");
  a_pattern_lines: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RQ8]
    test_sticky[umr_pkg::BIT_PATTERN] |=> (o_line_drive_en && o_line_dp != o_line_dm))
    else $error("pattern not driven");
  a_quiet_nak: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RQ10]
    test_sticky[umr_pkg::BIT_QUIET_NAK] |=> o_quiescent_nak_enable)
    else $error("quiescent nak missing");
  a_chip_rst_clear: assert property (@(posedge i_ref_clk) // [RQ2]
    i_sys_rst |=> (scratch_high_byte == 8'h00 && scratch_low_byte == 8'h00
    && test_reg == 8'h00 && !o_write_locked))
    else $error("chip reset left state");
  a_read_scratch: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RQ1]
    (i_host_read_strobe && hit(i_addr, umr_pkg::ADDR_SCRATCH))
    |=> o_rdata == $past({scratch_high_byte, scratch_low_byte}))
    else $error("scratch read wrong");
  a_read_hold: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RQ1]
    !i_host_read_strobe |=> $stable(o_rdata))
    else $error("read data changed without read");
  a_test_write: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RQ6]
    (write_ok && hit(i_addr, umr_pkg::ADDR_TEST) && !i_bus_rst)
    |=> test_reg == ($past(i_wdata[7:0]) & umr_pkg::TEST_WRITE_MASK))
    else $error("test register write wrong");
  a_lock_holds: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RQ4]
    (locked && !(i_host_write_strobe && hit(i_addr, umr_pkg::ADDR_UNLOCK)
    && i_wdata == umr_pkg::UNLOCK_KEY_VALUE)) |=> locked)
    else $error("lock released without key");
  a_j_state: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RQ9]
    (test_sticky[3:1] == 3'b001) |=> (o_line_drive_en && o_line_dp && !o_line_dm))
    else $error("J state wrong");
  a_quiet_lines: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RQ10]
    (test_sticky[3:0] == 4'b0001) |=> (o_line_drive_en && !o_line_dp && !o_line_dm))
    else $error("quiescent lines wrong");
  a_idle_lines: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RQ8]
    (test_sticky[3:0] == 4'h0) |=> !o_line_drive_en)
    else $error("lines driven without test mode");
  a_fs_sticks: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RQ13]
    o_force_full_speed |=> o_force_full_speed)
    else $error("full speed mode dropped");
  a_line_sticks: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst) // [RQ13]
    o_line_drive_en |=> o_line_drive_en)
    else $error("line test mode dropped");
endmodule

//--- bench/umr_host_model.sv
// Host microcontroller model on the parallel register port
`timescale 1ns/1ns
module umr_host_model (
  input wire logic i_ref_clk,
  input wire logic [15:0] i_rdata,
  output logic [7:0] o_addr,
  output logic [15:0] o_wdata,
  output logic o_wr,
  output logic o_rd
);
  initial
  begin
    o_addr = 8'h00;
    o_wdata = 16'h0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // Address and data are inverted once the strobe drops
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
  begin
    @(negedge i_ref_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_ref_clk);
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  end
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
  begin
    @(negedge i_ref_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_ref_clk);
    o_rd = 1'b0;
    o_addr = ~a;
    d = i_rdata;
  end
  endtask
  // Key goes in after a locked resume; the lock test first sends a scratch write and a wrong key, and both are ignored
  task automatic unlock;
  begin
    wr(umr_pkg::ADDR_UNLOCK, umr_pkg::UNLOCK_KEY_VALUE);
  end
  endtask
  // Callers pass at most one speed bit and one line bit
  task automatic set_test(input logic [7:0] m);
  begin
    wr(umr_pkg::ADDR_TEST, {8'h00, m});
  end
  endtask
endmodule

//--- bench/usb_misc_regs_unlock_test_bench.sv
// Self-checking bench for the scratch, unlock and line test registers
`timescale 1ns/1ns
module usb_misc_regs_unlock_test_bench;
  logic i_ref_clk = 1'b0;
  logic rst = 1'b1;
  logic bus_rst = 1'b0;
  logic susp = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] v;
  logic wr, rd, lk, fhs, ffs, chirp, en, dp, dm, nak;
  int errors = 0;
  int checks = 0;
  int cycles = 0;
  always #50 i_ref_clk = ~i_ref_clk;
  umr_regs u_dut (.i_ref_clk(i_ref_clk), .i_sys_rst(rst), .i_bus_rst(bus_rst),
    .i_suspend(susp), .i_processor_powered_flag(pwr), .i_addr(addr), .i_wdata(wdata),
    .i_host_write_strobe(wr), .i_host_read_strobe(rd), .o_rdata(rdata),
    .o_write_locked(lk), .o_force_high_speed(fhs), .o_force_full_speed(ffs),
    .o_chirp_disable(chirp), .o_line_drive_en(en), .o_line_dp(dp), .o_line_dm(dm),
    .o_quiescent_nak_enable(nak));
  umr_host_model u_host (.i_ref_clk(i_ref_clk), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
  begin
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: %h expected %h", $time, got, exp);
    end
  end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
  begin
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  task automatic do_reset;
  begin
    rst = 1'b1;
    cyc(4);
    rst = 1'b0;
  end
  endtask
  task automatic t_scratch;
  begin
    u_host.rd(umr_pkg::ADDR_SCRATCH, v);
    chk_word(v, 16'h0000);
    u_host.wr(umr_pkg::ADDR_SCRATCH, 16'hc3a5);
    u_host.rd(umr_pkg::ADDR_UNLOCK, v);
    chk_word(v, 16'h0000);
    u_host.rd(umr_pkg::ADDR_SCRATCH, v);
    chk_word(v, 16'hc3a5);
    u_host.set_test(8'h60);
    u_host.rd(umr_pkg::ADDR_TEST, v);
    chk_word(v, 16'h0000);
    cyc(2);
    chk_word({9'h000, en, dp, dm, nak, fhs, ffs, chirp}, 16'h0000);
    $display("scratch test done");
  end
  endtask
  task automatic t_lock;
  begin
    pwr = 1'b1;
    susp = 1'b1;
    cyc(3);
    chk_bit(lk, 1'b0);
    u_host.wr(umr_pkg::ADDR_SCRATCH, 16'h2222);
    u_host.rd(umr_pkg::ADDR_SCRATCH, v);
    chk_word(v, 16'h2222);
    susp = 1'b0;
    pwr = 1'b0;
    cyc(1);
    susp = 1'b1;
    cyc(3);
    chk_bit(lk, 1'b1);
    susp = 1'b0;
    u_host.wr(umr_pkg::ADDR_SCRATCH, 16'h3333);
    u_host.wr(umr_pkg::ADDR_UNLOCK, 16'haa36);
    u_host.rd(umr_pkg::ADDR_SCRATCH, v);
    chk_word(v, 16'h2222);
    chk_bit(lk, 1'b1);
    u_host.unlock();
    cyc(1);
    chk_bit(lk, 1'b0);
    u_host.wr(umr_pkg::ADDR_SCRATCH, 16'h4444);
    u_host.rd(umr_pkg::ADDR_SCRATCH, v);
    chk_word(v, 16'h4444);
    $display("lock test done");
  end
  endtask
  // Expected outputs as {en, dp, dm, nak, fhs, ffs, chirp}
  task automatic t_modes;
    logic [7:0] m [5] = '{8'h80, 8'h10, 8'h04, 8'h02, 8'h01};
    logic [6:0] e [5] = '{7'h05, 7'h03, 7'h50, 7'h60, 7'h48};
    for (int i = 0; i < 5; i++)
    begin
      do_reset();
      u_host.set_test(m[i]);
      cyc(2);
      chk_word({9'h000, en, dp, dm, nak, fhs, ffs, chirp}, {9'h000, e[i]});
      u_host.set_test(8'h00);
      cyc(2);
      chk_word({9'h000, en, dp, dm, nak, fhs, ffs, chirp}, {9'h000, e[i]});
    end
    $display("mode test done");
  endtask
  task automatic t_busrst;
  begin
    do_reset();
    u_host.wr(umr_pkg::ADDR_SCRATCH, 16'ha55a);
    u_host.set_test(8'h81);
    bus_rst = 1'b1;
    cyc(1);
    bus_rst = 1'b0;
    u_host.rd(umr_pkg::ADDR_TEST, v);
    chk_word(v, 16'h0080);
    u_host.rd(umr_pkg::ADDR_SCRATCH, v);
    chk_word(v, 16'h0000);
    chk_word({14'h0000, fhs, nak}, 16'h0003);
    $display("bus reset test done");
  end
  endtask
  task automatic t_pattern;
    int tog = 0;
    logic last;
    do_reset();
    u_host.set_test(8'h08);
    cyc(3);
    last = dp;
    repeat (16)
    begin
      chk_bit(en & (dp ^ dm), 1'b1);
      tog += int'(dp !== last);
      last = dp;
      cyc(1);
    end
    chk_bit(tog > 0, 1'b1);
    $display("pattern test done");
  endtask
  task automatic conclude;
  begin
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  always @(posedge i_ref_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errors++;
      conclude();
    end
  end
  initial
  begin
    do_reset();
    t_scratch();
    t_lock();
    t_modes();
    t_busrst();
    t_pattern();
    conclude();
  end
endmodule
